// File: verilog/fwd_decision.sv
// forwarding decision and table command engine of a three-port switch core
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module fwd_decision
	import fwd_pkg::*;
#(
	parameter int DEPTH = 512
)(
	input  wire logic                 SYS_CLK,
	input  wire logic                 RST_N,
	input  wire logic [fwd_pkg::AW-1:0] REG_ADDR,
	input  wire logic [fwd_pkg::DW-1:0] REG_WDATA,
	input  wire logic                 REG_WR,
	input  wire logic                 REG_RD,
	output logic      [fwd_pkg::DW-1:0] REG_RDATA,
	input  wire logic                 FRM_VALID,
	input  wire logic [1:0]           FRM_SRC,
	input  wire logic [47:0]          FRM_DA,
	input  wire logic                 FRM_TAGGED,
	input  wire logic [11:0]          FRM_VID,
	input  wire logic                 FRM_IGMP,
	input  wire logic                 FRM_MLD,
	input  wire logic                 FRM_NO_LOOKUP,
	input  wire logic                 FRM_YELLOW_SEL,
	input  wire logic                 FRM_RED,
	input  wire logic                 VID_FOUND,
	input  wire logic [fwd_pkg::NPORT-1:0] VID_MEMBERS,
	input  wire logic                 STORM_REACHED,
	input  wire logic                 BCAST_BUF_OVER,
	input  wire logic                 BUF_LOW,
	input  wire logic                 LEARN_REQ,
	input  wire logic [47:0]          LEARN_MAC,
	input  wire logic [1:0]           LEARN_PORT,
	output logic                      DEC_VALID,
	output logic [1:0]                DEC_ACTION,
	output logic [fwd_pkg::NPORT-1:0] DEC_PORTS,
	output logic                      DEC_PRIO_VALID,
	output logic [2:0]                DEC_PRIO
);
	import fwd_pkg::*;

	localparam int IW = $clog2(DEPTH);

	typedef enum logic [1:0] {CMD_IDLE, CMD_MAKE, CMD_SCAN} cmd_state_t;

	// configuration registers
	logic [DW-1:0]      lookup_cfg_r, glob_ing_r, redirect_r, port_state_r;
	logic [DW-1:0]      buf_cfg_r, admit_tag_r, port_ing_r, admit_nmem_r;
	logic [DW-1:0]      wr_lo_r, wr_hi_r, rd_lo_r, rd_hi_r;
	logic               pending_r;
	cmd_state_t         cmd_st_r;
	logic [IW-1:0]      idx_r;
	logic [IW-1:0]      hole_r;
	logic               hole_ok_r;
	logic [IW-1:0]      hit_idx_r;
	// table storage
	logic [47:0]        t_mac  [DEPTH];
	logic [NPORT-1:0]   t_ports[DEPTH];
	logic [2:0]         t_prio [DEPTH];
	logic [DEPTH-1:0]   t_pen, t_static, t_ovr, t_filt, t_valid;

	// port state of a given port
	function automatic logic [1:0] pstate(input logic [DW-1:0] r,
		input logic [1:0] p);
		pstate = r[2*p +: 2];
	endfunction

	// register decode
	wire cmd_wr   = REG_WR && REG_ADDR == A_TBL_CMD && !pending_r;
	wire do_make  = cmd_wr && REG_WDATA[B_MAKE];
	wire do_first = cmd_wr && REG_WDATA[B_GET_FIRST];
	wire do_next  = cmd_wr && REG_WDATA[B_GET_NEXT];

	// destination lookup, combinational search of the table
	logic              da_hit;
	logic [IW-1:0]     da_idx;
	always_comb
	begin
		da_hit = 1'b0;
		da_idx = '0;
		for (int i = 0; i < DEPTH; i++)
			if (!da_hit && t_valid[i] && t_mac[i] == FRM_DA)
			begin
				da_hit = 1'b1;
				da_idx = IW'(i);
			end
	end

	// frame classification
	wire              is_bcast = FRM_DA == BCAST_MAC;
	wire              is_mcast = FRM_DA[40] && !is_bcast;
	wire [NPORT-1:0]  e_ports  = t_ports[da_idx];
	wire              e_ovr    = da_hit && t_static[da_idx] && t_ovr[da_idx];
	wire              e_filt   = da_hit && t_filt[da_idx];
	wire              single   = da_hit && $countones(e_ports) == 1;
	wire              flood    = !da_hit || !single;
	wire [1:0]        dst_num  = e_ports[2] ? 2'd2 : (e_ports[1] ? 2'd1 : 2'd0);
	wire [1:0]        src_st   = pstate(port_state_r, FRM_SRC);
	wire [1:0]        dst_st   = pstate(port_state_r, dst_num);
	wire              redir_on = redirect_r[FRM_SRC];
	wire [NPORT-1:0]  redir_dst = redirect_r[4 + 3*FRM_SRC +: 3];
	wire              vlan_on  = glob_ing_r[B_VLAN_EN];
	wire              mchk     = vlan_on && port_ing_r[FRM_SRC];
	wire [NPORT-1:0]  members  = VID_FOUND ? VID_MEMBERS : '0;
	wire              snoop    = is_mcast && !FRM_NO_LOOKUP &&
		((FRM_IGMP && glob_ing_r[B_IGMP_EN]) ||
		 (FRM_MLD && glob_ing_r[B_MLD_EN]));

	// forwarding-state mask, override lifts all but disabled ports
	logic [NPORT-1:0] fwd_mask;
	genvar gp;
	generate
		for (gp = 0; gp < NPORT; gp++)
		begin : g_mask
			wire [1:0] st = port_state_r[2*gp +: 2];
			assign fwd_mask[gp] = st == ST_FWD ||
				(e_ovr && st != ST_DIS);
		end
	endgenerate

	wire [NPORT-1:0] src_bit  = NPORT'(1) << FRM_SRC;
	wire [NPORT-1:0] flood_base = da_hit ? e_ports : ~src_bit;
	wire [NPORT-1:0] fl_ports = flood_base & fwd_mask &
		(vlan_on && (mchk || !da_hit) ? members : '1);
	wire fl_zero_fwd = (flood_base & fwd_mask) == '0;
	wire fl_zero_vl  = vlan_on && (mchk || !da_hit) &&
		(flood_base & members) == '0;

	// filter conditions
	wire f_local = single && dst_num == FRM_SRC;
	wire f_src   = src_st == ST_DIS ||
		(src_st != ST_FWD && !e_ovr);
	wire f_dst   = single && !redir_on && (dst_st == ST_DIS ||
		(dst_st != ST_FWD && !e_ovr));
	wire f_unk   = !da_hit && ((!is_mcast && !is_bcast &&
		glob_ing_r[B_DROP_UNK]) || (is_mcast &&
		glob_ing_r[B_FILT_MC]));
	wire f_vlan  = vlan_on && ((!FRM_TAGGED || FRM_VID == '0) &&
		admit_tag_r[FRM_SRC] || FRM_TAGGED &&
		FRM_VID == VID_ALL_ONES);
	wire f_smem  = mchk && !admit_nmem_r[FRM_SRC] &&
		!members[FRM_SRC];
	wire f_dmem  = mchk && single && !redir_on && !members[dst_num];
	wire f_flood = flood && (fl_zero_fwd || fl_zero_vl);
	wire filtered = f_local || f_src || f_dst || e_filt || f_unk ||
		f_vlan || f_smem || f_dmem || f_flood;
	wire discard = (is_bcast && STORM_REACHED) ||
		(buf_cfg_r[B_DROP_YEL] && FRM_YELLOW_SEL) ||
		(buf_cfg_r[B_DROP_RED] && FRM_RED) ||
		(!da_hit && BCAST_BUF_OVER) || BUF_LOW;

	// destination choice: snoop, redirect, single, flood
	wire [NPORT-1:0] mon_ports = glob_ing_r[B_MON_LO +: NPORT];
	wire [NPORT-1:0] dst_sel = snoop ? mon_ports :
		redir_on ? redir_dst :
		single ? e_ports : fl_ports;
	wire prio_sel = da_hit && glob_ing_r[B_DA_PRIO] && t_pen[da_idx];

	// decision outputs, one cycle after frame offer
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			DEC_VALID      <= 1'b0;
			DEC_ACTION     <= ACT_FWD;
			DEC_PORTS      <= '0;
			DEC_PRIO_VALID <= 1'b0;
			DEC_PRIO       <= '0;
		end
		else
		begin
			DEC_VALID      <= FRM_VALID;
			DEC_ACTION     <= filtered ? ACT_FILTER :
				(discard ? ACT_DISCARD : ACT_FWD);
			DEC_PORTS      <= (filtered || discard) ? '0 : dst_sel;
			DEC_PRIO_VALID <= prio_sel;
			DEC_PRIO       <= t_prio[da_idx];
		end
	end

	// host-side entry match for make-entry
	wire [47:0] w_mac = {wr_hi_r[F_MAC_HI +: 16], wr_lo_r};
	wire        w_bc_bad = w_mac == BCAST_MAC &&
		!lookup_cfg_r[B_ALLOW_BCAST];

	// learned-address slot of a learn request
	logic              ln_hit;
	logic [IW-1:0]     ln_idx;
	logic              ln_free_ok;
	logic [IW-1:0]     ln_free;
	always_comb
	begin
		ln_hit = 1'b0;
		ln_idx = '0;
		ln_free_ok = 1'b0;
		ln_free = '0;
		for (int i = 0; i < DEPTH; i++)
		begin
			if (!ln_hit && t_valid[i] && t_mac[i] == LEARN_MAC)
			begin
				ln_hit = 1'b1;
				ln_idx = IW'(i);
			end
			if (!ln_free_ok && !t_valid[i])
			begin
				ln_free_ok = 1'b1;
				ln_free = IW'(i);
			end
		end
	end
	wire ln_go = LEARN_REQ && cmd_st_r != CMD_MAKE &&
		(ln_hit ? !t_static[ln_idx] : ln_free_ok);
	wire [IW-1:0] ln_slot = ln_hit ? ln_idx : ln_free;

	// make-entry slot: a match seen now wins at once, else the first hole,
	// so a match or the only hole in the last slot is not missed
	wire          mk_hit  = t_valid[idx_r] && t_mac[idx_r] == w_mac;
	wire          mk_room = mk_hit || hole_ok_r || !t_valid[idx_r];
	wire [IW-1:0] mk_slot = (mk_hit || !hole_ok_r) ? idx_r : hole_r;

	// command engine: make-entry searches, then writes; scan walks table
	wire last = idx_r == IW'(DEPTH - 1);
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			cmd_st_r  <= CMD_IDLE;
			pending_r <= 1'b0;
			idx_r     <= '0;
			hole_r    <= '0;
			hole_ok_r <= 1'b0;
			hit_idx_r <= '0;
			rd_lo_r   <= '0;
			rd_hi_r   <= '0;
			t_valid   <= '0;
			t_static  <= '0;
			t_ovr     <= '0;
			t_filt    <= '0;
			t_pen     <= '0;
		end
		else
		begin
			if (ln_go)
			begin
				t_mac[ln_slot]   <= LEARN_MAC;
				t_ports[ln_slot] <= NPORT'(1) << LEARN_PORT;
				t_valid[ln_slot] <= 1'b1;
				t_ovr[ln_slot]   <= 1'b1;
				// a reused hole must not inherit static or filter bits
				t_static[ln_slot] <= 1'b0;
				t_filt[ln_slot]   <= 1'b0;
				t_pen[ln_slot]    <= 1'b0;
			end
			unique case (cmd_st_r)
				CMD_IDLE:
				begin
					idx_r     <= '0;
					hole_ok_r <= 1'b0;
					if (do_make)
					begin
						pending_r <= 1'b1;
						cmd_st_r  <= CMD_MAKE;
					end
					else if (do_first || do_next)
					begin
						pending_r <= 1'b1;
						cmd_st_r  <= CMD_SCAN;
						if (do_next)
							idx_r <= rd_hi_r[F_END_TBL] ? idx_r :
								hit_idx_r + IW'(1);
					end
				end
				CMD_MAKE:
				begin
					if (!t_valid[idx_r] && !hole_ok_r)
					begin
						hole_ok_r <= 1'b1;
						hole_r    <= idx_r;
					end
					idx_r <= idx_r + IW'(1);
					if (last || mk_hit)
					begin
						// commit: update, add, or delete (valid=0)
						if (!w_bc_bad && mk_room)
						begin
							automatic logic [IW-1:0] s = mk_slot;
							t_mac[s]    <= w_mac;
							t_ports[s]  <= wr_hi_r[F_PORTS +: NPORT];
							t_prio[s]   <= wr_hi_r[F_PRIO +: 3];
							t_pen[s]    <= wr_hi_r[F_PRIO_EN];
							t_static[s] <= wr_hi_r[F_STATIC];
							t_ovr[s]    <= wr_hi_r[F_AGE1_OVR];
							t_filt[s]   <= wr_hi_r[F_AGE0_FILT];
							t_valid[s]  <= wr_hi_r[F_VALID];
						end
						pending_r <= 1'b0;
						cmd_st_r  <= CMD_IDLE;
					end
				end
				CMD_SCAN:
				begin
					idx_r <= idx_r + IW'(1);
					if (t_valid[idx_r] || last)
					begin
						rd_lo_r <= t_mac[idx_r][31:0];
						rd_hi_r <= {4'h0, last, t_valid[idx_r],
							t_filt[idx_r], t_ovr[idx_r],
							t_static[idx_r], t_pen[idx_r],
							t_prio[idx_r], t_ports[idx_r],
							t_mac[idx_r][47:32]};
						hit_idx_r <= idx_r;
						pending_r <= 1'b0;
						cmd_st_r  <= CMD_IDLE;
					end
				end
				default: cmd_st_r <= CMD_IDLE;
			endcase
		end
	end

	// software-written registers
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			lookup_cfg_r <= '0;
			glob_ing_r   <= '0;
			redirect_r   <= '0;
			port_state_r <= '0;
			buf_cfg_r    <= '0;
			admit_tag_r  <= '0;
			port_ing_r   <= '0;
			admit_nmem_r <= '0;
			wr_lo_r      <= '0;
			wr_hi_r      <= '0;
		end
		else if (REG_WR)
		begin
			unique case (REG_ADDR)
				A_LOOKUP_CFG: lookup_cfg_r <= REG_WDATA;
				A_GLOB_ING:   glob_ing_r   <= REG_WDATA;
				A_REDIRECT:   redirect_r   <= REG_WDATA;
				A_PORT_STATE: port_state_r <= REG_WDATA;
				A_BUF_CFG:    buf_cfg_r    <= REG_WDATA;
				A_ADMIT_TAG:  admit_tag_r  <= REG_WDATA;
				A_PORT_ING:   port_ing_r   <= REG_WDATA;
				A_ADMIT_NMEM: admit_nmem_r <= REG_WDATA;
				A_WR_LO:      wr_lo_r      <= REG_WDATA;
				A_WR_HI:      wr_hi_r      <= REG_WDATA;
				default:      ;
			endcase
		end
	end

	// read mux, data one cycle after the strobe
	logic [DW-1:0] rd_mux;
	always_comb
	begin
		unique case (REG_ADDR)
			A_LOOKUP_CFG: rd_mux = lookup_cfg_r;
			A_GLOB_ING:   rd_mux = glob_ing_r;
			A_REDIRECT:   rd_mux = redirect_r;
			A_TBL_STS:    rd_mux = {31'h0, pending_r};
			A_WR_LO:      rd_mux = wr_lo_r;
			A_WR_HI:      rd_mux = wr_hi_r;
			A_RD_LO:      rd_mux = rd_lo_r;
			A_RD_HI:      rd_mux = rd_hi_r;
			A_PORT_STATE: rd_mux = port_state_r;
			A_BUF_CFG:    rd_mux = buf_cfg_r;
			A_ADMIT_TAG:  rd_mux = admit_tag_r;
			A_PORT_ING:   rd_mux = port_ing_r;
			A_ADMIT_NMEM: rd_mux = admit_nmem_r;
			default:      rd_mux = '0;
		endcase
	end
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
			REG_RDATA <= '0;
		else if (REG_RD)
			REG_RDATA <= rd_mux;
		else
			REG_RDATA <= '0;
	end
endmodule // fwd_decision

// File: verilog/fwd_pkg.sv
// shared constants for the forwarding decision block
package fwd_pkg;
	localparam int NPORT    = 3;
	localparam int AW       = 4;
	localparam int DW       = 32;
	localparam int TBL_IDXW = 9;
	// register offsets
	localparam logic [3:0] A_LOOKUP_CFG  = 4'h0;
	localparam logic [3:0] A_GLOB_ING    = 4'h1;
	localparam logic [3:0] A_REDIRECT    = 4'h2;
	localparam logic [3:0] A_TBL_CMD     = 4'h3;
	localparam logic [3:0] A_TBL_STS     = 4'h4;
	localparam logic [3:0] A_WR_LO       = 4'h5;
	localparam logic [3:0] A_WR_HI       = 4'h6;
	localparam logic [3:0] A_RD_LO       = 4'h7;
	localparam logic [3:0] A_RD_HI       = 4'h8;
	localparam logic [3:0] A_PORT_STATE  = 4'h9;
	localparam logic [3:0] A_BUF_CFG     = 4'hA;
	localparam logic [3:0] A_ADMIT_TAG   = 4'hB;
	localparam logic [3:0] A_PORT_ING    = 4'hC;
	localparam logic [3:0] A_ADMIT_NMEM  = 4'hD;
	// lookup_config bits
	localparam int B_ALLOW_BCAST = 0;
	// global_ingress_config bits
	localparam int B_DA_PRIO     = 0;
	localparam int B_DROP_UNK    = 1;
	localparam int B_FILT_MC     = 2;
	localparam int B_IGMP_EN     = 3;
	localparam int B_MLD_EN      = 4;
	localparam int B_VLAN_EN     = 5;
	localparam int B_MON_LO      = 8;   // monitor port mask [10:8]
	// buffer_manager_config bits
	localparam int B_DROP_YEL    = 0;
	localparam int B_DROP_RED    = 1;
	// table_command_reg bits
	localparam int B_MAKE        = 0;
	localparam int B_GET_NEXT    = 1;
	localparam int B_GET_FIRST   = 2;
	// table_command_status bit
	localparam int B_PENDING     = 0;
	// write/read data hi field layout (lo = mac[31:0])
	localparam int F_MAC_HI      = 0;   // [15:0]
	localparam int F_PORTS       = 16;  // [18:16]
	localparam int F_PRIO        = 19;  // [21:19]
	localparam int F_PRIO_EN     = 22;
	localparam int F_STATIC      = 23;
	localparam int F_AGE1_OVR    = 24;
	localparam int F_AGE0_FILT   = 25;
	localparam int F_VALID       = 26;
	localparam int F_END_TBL     = 27;
	// port tree states, two bits per port
	localparam logic [1:0] ST_FWD  = 2'h0;
	localparam logic [1:0] ST_BLK  = 2'h1;
	localparam logic [1:0] ST_LRN  = 2'h2;
	localparam logic [1:0] ST_DIS  = 2'h3;
	localparam logic [47:0] BCAST_MAC = 48'hFFFFFFFFFFFF;
	localparam logic [11:0] VID_ALL_ONES = 12'hFFF;
	typedef enum logic [1:0] {ACT_FWD, ACT_FILTER, ACT_DISCARD} action_t;
endpackage

// File: test/fwd_decision_properties.sv
// assertion checker for the forwarding decision ports
`timescale 1ns/100ps
module fwd_decision_properties
	import fwd_pkg::*;
#(
	parameter int DEPTH = 512
)(
	input wire logic			SYS_CLK,
	input wire logic			RST_N,
	input wire logic [fwd_pkg::AW-1:0]	REG_ADDR,
	input wire logic [fwd_pkg::DW-1:0]	REG_WDATA,
	input wire logic			REG_WR,
	input wire logic			REG_RD,
	input wire logic [fwd_pkg::DW-1:0]	REG_RDATA,
	input wire logic			FRM_VALID,
	input wire logic [1:0]			FRM_SRC,
	input wire logic [47:0]			FRM_DA,
	input wire logic			FRM_TAGGED,
	input wire logic [11:0]			FRM_VID,
	input wire logic			FRM_RED,
	input wire logic			STORM_REACHED,
	input wire logic			BUF_LOW,
	input wire logic			DEC_VALID,
	input wire logic [1:0]			DEC_ACTION,
	input wire logic [fwd_pkg::NPORT-1:0]	DEC_PORTS
);
	import fwd_pkg::*;

	logic		vlan_r;
	logic		red_r;
	logic [5:0]	state_r;
	logic [1:0]	src_st;
	// tree state of the frame's source port
	assign src_st = state_r[FRM_SRC*2 +: 2];
	// shadow of the settings the checks depend on
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			state_r <= 6'h00;
			vlan_r <= 1'b0;
			red_r <= 1'b0;
		end
		else if (REG_WR)
		begin
			if (REG_ADDR == A_PORT_STATE) state_r <= REG_WDATA[5:0];
			if (REG_ADDR == A_GLOB_ING) vlan_r <= REG_WDATA[B_VLAN_EN];
			if (REG_ADDR == A_BUF_CFG) red_r <= REG_WDATA[B_DROP_RED];
		end
	end
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	AST_DEC_NEXT: assert property (FRM_VALID |=> DEC_VALID)
		else $error("decision missing one cycle after frame");
	AST_SRC_DIS: assert property (FRM_VALID && src_st == ST_DIS
		|=> DEC_ACTION == ACT_FILTER) else $error("disabled source passed");
	AST_STORM: assert property (FRM_VALID && FRM_DA == BCAST_MAC
		&& STORM_REACHED |=> DEC_ACTION != ACT_FWD)
		else $error("broadcast forwarded in storm");
	AST_RED: assert property (FRM_VALID && FRM_RED && red_r
		|=> DEC_ACTION != ACT_FWD) else $error("red frame forwarded");
	AST_NO_BUF: assert property (FRM_VALID && BUF_LOW
		|=> DEC_ACTION != ACT_FWD) else $error("forwarded without buffer");
	AST_VID_ONES: assert property (FRM_VALID && vlan_r && FRM_TAGGED
		&& FRM_VID == VID_ALL_ONES |=> DEC_ACTION == ACT_FILTER)
		else $error("all-ones vid passed");
	AST_FWD_PORTS: assert property (DEC_VALID && DEC_ACTION == ACT_FWD
		|-> DEC_PORTS != 3'h0) else $error("forward with no ports");
	AST_DROP_PORTS: assert property (DEC_VALID && DEC_ACTION != ACT_FWD
		|-> DEC_PORTS == 3'h0) else $error("ports on dropped frame");
	AST_PENDING: assert property (REG_WR && REG_ADDR == A_TBL_CMD
		&& REG_WDATA[2:0] != 3'h0 ##1 REG_RD && REG_ADDR == A_TBL_STS
		|=> REG_RDATA[B_PENDING]) else $error("pending not set");
endmodule // fwd_decision_properties

bind fwd_decision fwd_decision_properties #(.DEPTH(DEPTH)) chk (.SYS_CLK,
	.RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .FRM_VALID,
	.FRM_SRC, .FRM_DA, .FRM_TAGGED, .FRM_VID, .FRM_RED, .STORM_REACHED,
	.BUF_LOW, .DEC_VALID, .DEC_ACTION, .DEC_PORTS);

// File: test/frm_source.sv
// ingress side model: frame attributes with buffer and vlan conditions
`timescale 1ns/100ps
module frm_source
	import fwd_pkg::*;
(
	input wire logic		clk,
	output logic			valid,
	output logic [1:0]		src,
	output logic [47:0]		da,
	output logic [11:0]		vid,
	output logic [9:0]		cond,
	output logic [NPORT-1:0]	mem
);
	// idle lines carry no stale frame
	initial
	begin
		valid = 1'b0;
		src = 2'h0;
		da = 48'h0;
		vid = 12'h0;
		cond = 10'h0;
		mem = 3'h0;
	end
	// one frame for one cycle, then the lines show the inverse
	task automatic send(input logic [1:0] s, input logic [47:0] a,
		input logic [11:0] v, input logic [2:0] m, input logic [9:0] c);
		@(posedge clk);
		valid <= 1'b1;
		src <= s;
		da <= a;
		vid <= v;
		cond <= c;
		mem <= m;
		@(posedge clk);
		valid <= 1'b0;
		src <= ~s;
		da <= ~a;
		vid <= ~v;
		cond <= ~c;
		mem <= ~m;
	endtask
endmodule // frm_source

// File: test/tb_top.sv
// self-checking bench for the forwarding decision block
`timescale 1ns/100ps
module tb_top;
	import fwd_pkg::*;
	localparam logic [47:0] MA = 48'h00000A000001;
	localparam logic [47:0] MB = 48'h00000B000002;
	localparam logic [47:0] MC = 48'h00000C000003;
	localparam logic [47:0] MU = 48'h00000D000004;
	localparam logic [47:0] MM = 48'h01005E000001;
	localparam logic [2:0]	ANY = 3'bxxx;
	localparam logic [9:0]	TV = 10'h201;
	logic		clk = 1'b0;
	logic		rst_n = 1'b0;
	logic [AW-1:0]	addr = '0;
	logic [DW-1:0]	wdata = '0;
	logic		wr = 1'b0;
	logic		rd = 1'b0;
	logic		lrn = 1'b0;
	logic [47:0]	lrn_mac = '0;
	logic [1:0]	lrn_port = '0;
	logic [DW-1:0]	rdata;
	logic [DW-1:0]	d;
	logic		f_valid;
	logic [1:0]	f_src;
	logic [47:0]	f_da;
	logic [11:0]	f_vid;
	logic [9:0]	f_cond;
	logic [2:0]	f_mem;
	logic		d_valid;
	logic [1:0]	d_act;
	logic [2:0]	d_ports;
	logic		p_valid;
	logic [2:0]	prio;
	int		err_count = 0;
	int		n_checks = 0;
	int		n;
	always #50 clk = ~clk;
	frm_source src (.clk(clk), .valid(f_valid), .src(f_src), .da(f_da),
		.vid(f_vid), .cond(f_cond), .mem(f_mem));
	fwd_decision #(.DEPTH(16)) uut (.SYS_CLK(clk), .RST_N(rst_n),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdata), .FRM_VALID(f_valid), .FRM_SRC(f_src),
		.FRM_DA(f_da), .FRM_TAGGED(f_cond[0]), .FRM_VID(f_vid),
		.FRM_IGMP(f_cond[1]), .FRM_MLD(f_cond[2]),
		.FRM_NO_LOOKUP(f_cond[3]), .FRM_YELLOW_SEL(f_cond[4]),
		.FRM_RED(f_cond[5]), .VID_FOUND(f_cond[9]), .VID_MEMBERS(f_mem),
		.STORM_REACHED(f_cond[6]), .BCAST_BUF_OVER(f_cond[7]),
		.BUF_LOW(f_cond[8]), .LEARN_REQ(lrn), .LEARN_MAC(lrn_mac),
		.LEARN_PORT(lrn_port), .DEC_VALID(d_valid), .DEC_ACTION(d_act),
		.DEC_PORTS(d_ports), .DEC_PRIO_VALID(p_valid), .DEC_PRIO(prio));
	task automatic give_verdict();
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk_val(input logic [DW-1:0] g, input logic [DW-1:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected value at %0t: %h not %h", $time, g, e);
		end
	endtask
	task automatic chk_dec(input logic [1:0] ea, input logic [2:0] ep);
		n_checks++;
		if (d_valid !== 1'b1 || d_act !== ea || (ep !== ANY && d_ports !== ep))
		begin
			err_count++;
			$display("unexpected decision at %0t: %h %b", $time, d_act, d_ports);
		end
	endtask
	task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [AW-1:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// command write, status read right behind it, then bounded poll
	task automatic cmd(input logic [2:0] c);
		int i;
		wr_reg(A_TBL_CMD, {29'h0, c});
		addr <= A_TBL_STS;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_val({31'h0, rdata[B_PENDING]}, 32'h1);
		for (i = 0; i < 40; i++)
		begin
			rd_reg(A_TBL_STS);
			if (d[B_PENDING] === 1'b0) break;
		end
		if (i == 40)
		begin
			err_count++;
			give_verdict();
		end
	endtask
	task automatic mk(input logic [47:0] m, input logic [11:0] ctl);
		wr_reg(A_WR_LO, m[31:0]);
		wr_reg(A_WR_HI, {4'h0, ctl, m[47:32]});
		cmd(3'h1);
	endtask
	task automatic fr(input logic [1:0] s, input logic [47:0] a,
		input logic [1:0] ea, input logic [2:0] ep,
		input logic [9:0] c = 10'h0, input logic [2:0] m = 3'h7);
		src.send(s, a, 12'h5, m, c);
		#1;
		chk_dec(ea, ep);
	endtask
	// main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(A_TBL_STS);
		chk_val(d, 32'h0);
		rd_reg(4'hF);
		chk_val(d, 32'h0);
		mk(MA, 12'h4EA);
		mk(MB, 12'h582);
		mk(MC, 12'h682);
		mk(BCAST_MAC, 12'h681);
		@(posedge clk);
		lrn <= 1'b1;
		lrn_mac <= MA;
		lrn_port <= 2'h2;
		@(posedge clk);
		lrn <= 1'b0;
		wr_reg(A_GLOB_ING, 32'h1);
		fr(2'h0, MA, ACT_FWD, 3'h2);
		chk_val({28'h0, p_valid, prio}, 32'hD);
		fr(2'h1, MA, ACT_FILTER, 3'h0);
		fr(2'h1, BCAST_MAC, ACT_FWD, 3'h5);
		wr_reg(A_LOOKUP_CFG, 32'h1);
		mk(BCAST_MAC, 12'h681);
		fr(2'h1, BCAST_MAC, ACT_FILTER, 3'h0);
		fr(2'h0, MC, ACT_FILTER, 3'h0);
		wr_reg(A_PORT_STATE, 32'h4);
		fr(2'h0, MA, ACT_FILTER, 3'h0);
		fr(2'h0, MB, ACT_FWD, 3'h2);
		chk_val({28'h0, p_valid, prio}, 32'h0);
		wr_reg(A_PORT_STATE, 32'hC);
		fr(2'h0, MB, ACT_FILTER, 3'h0);
		wr_reg(A_PORT_STATE, 32'h2);
		fr(2'h0, MA, ACT_FILTER, 3'h0);
		fr(2'h0, MB, ACT_FWD, 3'h2);
		wr_reg(A_PORT_STATE, 32'h3);
		fr(2'h0, MB, ACT_FILTER, 3'h0);
		wr_reg(A_PORT_STATE, 32'h4);
		fr(2'h0, MU, ACT_FWD, 3'h4);
		wr_reg(A_PORT_STATE, 32'h14);
		fr(2'h0, MU, ACT_FILTER, 3'h0);
		wr_reg(A_PORT_STATE, 32'h0);
		fr(2'h0, MU, ACT_FWD, 3'h6);
		wr_reg(A_GLOB_ING, 32'h3);
		fr(2'h0, MU, ACT_FILTER, 3'h0);
		fr(2'h0, MM, ACT_FWD, 3'h6);
		wr_reg(A_GLOB_ING, 32'h7);
		fr(2'h0, MM, ACT_FILTER, 3'h0);
		mk(BCAST_MAC, 12'h001);
		fr(2'h1, BCAST_MAC, ACT_DISCARD, 3'h0, 10'h040);
		fr(2'h1, BCAST_MAC, ACT_DISCARD, 3'h0, 10'h080);
		fr(2'h0, MA, ACT_FWD, 3'h2, 10'h080);
		fr(2'h0, MA, ACT_DISCARD, 3'h0, 10'h100);
		wr_reg(A_BUF_CFG, 32'h2);
		fr(2'h0, MA, ACT_DISCARD, 3'h0, 10'h020);
		fr(2'h0, MA, ACT_FWD, 3'h2, 10'h010);
		wr_reg(A_BUF_CFG, 32'h1);
		fr(2'h0, MA, ACT_DISCARD, 3'h0, 10'h010);
		fr(2'h0, MA, ACT_FWD, 3'h2, 10'h020);
		wr_reg(A_GLOB_ING, 32'h1);
		wr_reg(A_REDIRECT, 32'h41);
		wr_reg(A_PORT_STATE, 32'h4);
		fr(2'h0, MA, ACT_FWD, 3'h4);
		chk_val({28'h0, p_valid, prio}, 32'hD);
		fr(2'h0, MC, ACT_FILTER, 3'h0);
		wr_reg(A_REDIRECT, 32'h0);
		wr_reg(A_PORT_STATE, 32'h0);
		wr_reg(A_GLOB_ING, 32'h109);
		fr(2'h1, MM, ACT_FWD, 3'h1, 10'h002);
		wr_reg(A_GLOB_ING, 32'h111);
		fr(2'h1, MM, ACT_FWD, 3'h1, 10'h004);
		fr(2'h1, MM, ACT_FWD, 3'h5, 10'h00C);
		wr_reg(A_GLOB_ING, 32'h21);
		wr_reg(A_ADMIT_TAG, 32'h1);
		fr(2'h0, MA, ACT_FILTER, 3'h0, 10'h200);
		fr(2'h0, MA, ACT_FWD, 3'h2, TV);
		wr_reg(A_ADMIT_TAG, 32'h0);
		src.send(2'h0, MA, VID_ALL_ONES, 3'h7, TV);
		#1;
		chk_dec(ACT_FILTER, 3'h0);
		wr_reg(A_PORT_ING, 32'h1);
		fr(2'h0, MA, ACT_FILTER, 3'h0, TV, 3'h2);
		wr_reg(A_ADMIT_NMEM, 32'h1);
		fr(2'h0, MA, ACT_FWD, 3'h2, TV, 3'h2);
		fr(2'h0, MA, ACT_FILTER, 3'h0, TV, 3'h1);
		wr_reg(A_PORT_ING, 32'h0);
		fr(2'h0, MU, ACT_FILTER, 3'h0, 10'h001, 3'h0);
		n = 0;
		cmd(3'h4);
		for (int k = 0; k < 20; k++)
		begin
			rd_reg(A_RD_HI);
			if (d[F_VALID] === 1'b1) n++;
			if (d[F_END_TBL] !== 1'b0) break;
			cmd(3'h2);
		end
		chk_val(n, 32'd3);
		give_verdict();
	end
endmodule // tb_top
